/* File: core/pst_pkg.sv */
// Constants and types shared by the parameter-set trigger sequencer.
package pst_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NSETS     = 16;
    localparam int unsigned CFG_W     = 13;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLE    = 8'h00;
    localparam logic [7:0] OFS_CTRL      = 8'h04;
    localparam logic [7:0] OFS_ITER_TOT  = 8'h08;
    localparam logic [7:0] OFS_SET_RANGE = 8'h0c;
    localparam logic [7:0] OFS_SW_START  = 8'h10;
    localparam logic [7:0] OFS_DMA_SIG   = 8'h14;
    localparam logic [7:0] OFS_DONE      = 8'h18;
    localparam logic [7:0] OFS_DONE_CLR  = 8'h1c;
    localparam logic [7:0] OFS_CPU_KICK  = 8'h20;
    localparam logic [7:0] OFS_CUR_SET   = 8'h24;
    localparam logic [7:0] OFS_CUR_ITER  = 8'h28;
    localparam logic [7:0] OFS_SEEN      = 8'h2c;
    localparam logic [7:0] OFS_SEEN_CLR  = 8'h30;
    localparam logic [1:0] CFG_AREA_TAG  = 2'h1;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_SHARE_BIT = 0;
    localparam int unsigned RANGE_LAST_LSB = 4;
    localparam int unsigned SEEN_SW_BIT    = 1;
    localparam int unsigned SEEN_PING_BIT  = 2;
    localparam int unsigned SEEN_DMA_LSB   = 3;
    localparam logic [2:0]  ENABLE_ON      = 3'h7;
    localparam logic [11:0] LOOP_FOREVER   = 12'hfff;
    localparam logic [11:0] LOOP_OFF       = 12'h000;
    localparam logic [18:0] SEEN_RST       = 19'h00001;

    // ------------------------------------------------------------------
    // Trigger modes and sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PST_MODE_IMM  = 3'b000,
        PST_MODE_SW   = 3'b001,
        PST_MODE_PING = 3'b010,
        PST_MODE_DMA  = 3'b011
    } pst_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LOAD   = 3'b001,
        ST_WAIT   = 3'b010,
        ST_RUN    = 3'b011,
        ST_FINISH = 3'b100,
        ST_STOP   = 3'b101
    } pst_state_t;

    // Per-set word: mode [2:0], src [6:3], irq [7], kick [8], dst [12:9].
    typedef struct packed {
        logic [3:0] dst;
        logic       kick_en;
        logic       irq_en;
        logic [3:0] src;
        logic [2:0] mode;
    } pst_set_cfg_t;

endpackage

/* File: core/pst_cfg_table.sv */
// Per-parameter-set configuration storage with two read ports.
`timescale 1ns/1ns
module pst_cfg_table (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Masked write port
    input  wire logic                  wr_en_i,
    input  wire logic [3:0]            wr_idx_i,
    input  pst_pkg::pst_set_cfg_t      wr_cfg_i,
    input  pst_pkg::pst_set_cfg_t      wr_mask_i,
    // Read ports
    input  wire logic [3:0]            rd_a_idx_i,
    input  wire logic [3:0]            rd_b_idx_i,
    output pst_pkg::pst_set_cfg_t      rd_a_cfg_o,
    output pst_pkg::pst_set_cfg_t      rd_b_cfg_o
);

    pst_pkg::pst_set_cfg_t entry_r [pst_pkg::NSETS];

    // ------------------------------------------------------------------
    // One flip-flop entry per parameter set.
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < pst_pkg::NSETS; g++) begin : g_entry
            // Entry takes the masked write when its index is addressed.
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    entry_r[g] <= '0;
                end else if (wr_en_i && wr_idx_i == 4'(g)) begin
                    entry_r[g] <= (entry_r[g] & ~wr_mask_i)
                                | (wr_cfg_i & wr_mask_i);
                end
            end
        end
    endgenerate

    // Read selection by index.
    assign rd_a_cfg_o = entry_r[rd_a_idx_i];
    assign rd_b_cfg_o = entry_r[rd_b_idx_i];

endmodule

/* File: core/pst_sequencer.sv */
// Parameter-set trigger sequencer with a classic Wishbone register slave.
`timescale 1ns/1ns
module pst_sequencer (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Compute engine handshake
    input  wire logic        pingpong_switch_i,
    input  wire logic        compute_done_i,
    output logic             compute_start_o,
    output logic      [3:0]  active_set_o,
    // Completion events
    output logic             done_irq_o,
    output logic      [15:0] dma_kick_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pst_pkg::pst_state_t   state_r;
    pst_pkg::pst_state_t   state_nxt;
    pst_pkg::pst_set_cfg_t cur_cfg;
    pst_pkg::pst_set_cfg_t bus_cfg;
    pst_pkg::pst_set_cfg_t cfg_wr_mask;
    logic [2:0]  enable_r;
    logic        share_r;
    logic [11:0] iter_tot_r;
    logic [3:0]  first_r;
    logic [3:0]  last_r;
    logic        sw_start_r;
    logic        sw_start_nxt;
    logic [15:0] sig_r;
    logic [15:0] sig_nxt;
    logic [15:0] done_r;
    logic [15:0] done_nxt;
    logic [18:0] seen_r;
    logic [18:0] seen_nxt;
    logic [3:0]  idx_r;
    logic [11:0] loop_r;
    logic        ping_pend_r;
    logic        ping_pend_nxt;
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        irq_r;
    logic [15:0] kick_r;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    wire logic        bus_req   = wb_cyc_i && wb_stb_i && !ack_r;
    wire logic        wr_fire   = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    wire logic [7:0]  adr_w     = {wb_adr_i[7:2], 2'h0};
    wire logic        cfg_hit   = adr_w[7:6] == pst_pkg::CFG_AREA_TAG;
    wire logic [31:0] wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wval      = wb_dat_i & wmask;
    wire logic        wr_en_w   = wr_fire && adr_w == pst_pkg::OFS_ENABLE;
    wire logic        wr_ctrl   = wr_fire && adr_w == pst_pkg::OFS_CTRL;
    wire logic        wr_iter   = wr_fire && adr_w == pst_pkg::OFS_ITER_TOT;
    wire logic        wr_range  = wr_fire && adr_w == pst_pkg::OFS_SET_RANGE;
    wire logic        wr_sw     = wr_fire && adr_w == pst_pkg::OFS_SW_START;
    wire logic        wr_sig    = wr_fire && adr_w == pst_pkg::OFS_DMA_SIG;
    wire logic        wr_dclr   = wr_fire && adr_w == pst_pkg::OFS_DONE_CLR;
    wire logic        wr_kick   = wr_fire && adr_w == pst_pkg::OFS_CPU_KICK;
    wire logic        wr_sclr   = wr_fire && adr_w == pst_pkg::OFS_SEEN_CLR;
    wire logic        wr_cfg    = wr_fire && cfg_hit;

    // ------------------------------------------------------------------
    // Per-set configuration table
    // ------------------------------------------------------------------
    assign cfg_wr_mask = pst_pkg::pst_set_cfg_t'(wmask[12:0]);

    pst_cfg_table u_cfg (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_cfg),
        .wr_idx_i   (adr_w[5:2]),
        .wr_cfg_i   (pst_pkg::pst_set_cfg_t'(wb_dat_i[12:0])),
        .wr_mask_i  (cfg_wr_mask),
        .rd_a_idx_i (adr_w[5:2]),
        .rd_b_idx_i (idx_r),
        .rd_a_cfg_o (bus_cfg),
        .rd_b_cfg_o (cur_cfg)
    );

    // ------------------------------------------------------------------
    // Trigger qualification
    // ------------------------------------------------------------------
    wire logic run_ok   = enable_r == pst_pkg::ENABLE_ON
                       && iter_tot_r != pst_pkg::LOOP_OFF;
    wire logic is_imm   = cur_cfg.mode == pst_pkg::PST_MODE_IMM;
    wire logic is_sw    = cur_cfg.mode == pst_pkg::PST_MODE_SW;
    wire logic is_ping  = cur_cfg.mode == pst_pkg::PST_MODE_PING;
    wire logic is_dma   = cur_cfg.mode == pst_pkg::PST_MODE_DMA;
    wire logic sig_bit  = sig_r[cur_cfg.src];
    wire logic trig_ok  = is_imm
                       || (is_sw && sw_start_r)
                       || (is_ping && share_r && ping_pend_r)
                       || (is_dma && sig_bit);
    wire logic in_wait  = state_r == pst_pkg::ST_WAIT;
    wire logic go       = in_wait && run_ok && trig_ok;
    wire logic in_fin   = state_r == pst_pkg::ST_FINISH && run_ok;
    wire logic at_last  = idx_r == last_r;
    wire logic [11:0] loop_inc = 12'(loop_r + 12'h001);
    wire logic loop_end = at_last && iter_tot_r != pst_pkg::LOOP_FOREVER
                       && loop_inc == iter_tot_r;
    wire logic fin_irq  = in_fin && cur_cfg.irq_en;
    wire logic fin_kick = in_fin && cur_cfg.kick_en;
    wire logic [15:0] kick_sel = 16'h0001 << cur_cfg.dst;
    wire logic [15:0] idx_hot  = 16'h0001 << idx_r;
    wire logic [15:0] src_hot  = 16'h0001 << cur_cfg.src;

    assign compute_start_o = go;
    assign active_set_o    = idx_r;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pst_pkg::ST_IDLE: begin
                if (run_ok) begin
                    state_nxt = pst_pkg::ST_LOAD;
                end
            end
            pst_pkg::ST_LOAD: begin
                state_nxt = pst_pkg::ST_WAIT;
            end
            pst_pkg::ST_WAIT: begin
                if (go) begin
                    state_nxt = pst_pkg::ST_RUN;
                end
            end
            pst_pkg::ST_RUN: begin
                if (compute_done_i) begin
                    state_nxt = pst_pkg::ST_FINISH;
                end
            end
            pst_pkg::ST_FINISH: begin
                state_nxt = loop_end ? pst_pkg::ST_STOP
                                     : pst_pkg::ST_LOAD;
            end
            pst_pkg::ST_STOP: begin
                state_nxt = pst_pkg::ST_STOP;
            end
            default: begin
                state_nxt = pst_pkg::ST_IDLE;
            end
        endcase
        if (!run_ok) begin
            state_nxt = pst_pkg::ST_IDLE;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= pst_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Set index and loop counter; wrap to the first set after the last.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_r  <= 4'h0;
            loop_r <= 12'h000;
        end else if (state_r == pst_pkg::ST_IDLE && run_ok) begin
            idx_r  <= first_r;
            loop_r <= 12'h000;
        end else if (in_fin && at_last) begin
            idx_r  <= first_r;
            loop_r <= loop_inc;
        end else if (in_fin) begin
            idx_r  <= 4'(idx_r + 4'h1);
        end
    end

    // ------------------------------------------------------------------
    // Trigger sources; a bus write wins over a consume in the same cycle.
    // ------------------------------------------------------------------
    always_comb begin
        sw_start_nxt  = sw_start_r;
        sig_nxt       = sig_r;
        ping_pend_nxt = ping_pend_r;
        if (go && is_sw) begin
            sw_start_nxt = 1'b0;
        end
        if (go && is_dma) begin
            sig_nxt = sig_r & ~src_hot;
        end
        if (go && is_ping) begin
            ping_pend_nxt = 1'b0;
        end
        if (pingpong_switch_i && share_r) begin
            ping_pend_nxt = 1'b1;
        end
        if (!share_r) begin
            ping_pend_nxt = 1'b0;
        end
        if (wr_sw && wb_sel_i[0]) begin
            sw_start_nxt = wb_dat_i[0];
        end
        if (wr_sig) begin
            sig_nxt = (sig_nxt & ~wmask[15:0]) | wval[15:0];
        end
    end

    // Done and trigger-seen flags; a set wins over a clear.
    always_comb begin
        done_nxt = done_r & ~(wr_dclr ? wval[15:0] : 16'h0000);
        if (in_fin) begin
            done_nxt = done_nxt | idx_hot;
        end
        seen_nxt = (wr_sclr && wval[0]) ? pst_pkg::SEEN_RST : seen_r;
        if (wr_sw && wval[0]) begin
            seen_nxt[pst_pkg::SEEN_SW_BIT] = 1'b1;
        end
        if (pingpong_switch_i && share_r) begin
            seen_nxt[pst_pkg::SEEN_PING_BIT] = 1'b1;
        end
        if (wr_sig) begin
            seen_nxt[18:pst_pkg::SEEN_DMA_LSB] =
                seen_nxt[18:pst_pkg::SEEN_DMA_LSB] | wval[15:0];
        end
        seen_nxt[0] = 1'b1;
    end

    // Flag and trigger source registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_start_r  <= 1'b0;
            sig_r       <= 16'h0000;
            ping_pend_r <= 1'b0;
            done_r      <= 16'h0000;
            seen_r      <= pst_pkg::SEEN_RST;
        end else begin
            sw_start_r  <= sw_start_nxt;
            sig_r       <= sig_nxt;
            ping_pend_r <= ping_pend_nxt;
            done_r      <= done_nxt;
            seen_r      <= seen_nxt;
        end
    end

    // Completion events: interrupt pulse and DMA kicks, software kicks merged.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r  <= 1'b0;
            kick_r <= 16'h0000;
        end else begin
            irq_r  <= fin_irq;
            kick_r <= (fin_kick ? kick_sel : 16'h0000)
                    | (wr_kick ? wval[15:0] : 16'h0000);
        end
    end

    assign done_irq_o = irq_r;
    assign dma_kick_o = kick_r;

    // ------------------------------------------------------------------
    // Common control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r   <= 3'h0;
            share_r    <= 1'b0;
            iter_tot_r <= 12'h000;
            first_r    <= 4'h0;
            last_r     <= 4'h0;
        end else begin
            if (wr_en_w && wb_sel_i[0]) begin
                enable_r <= wb_dat_i[2:0];
            end
            if (wr_ctrl && wb_sel_i[0]) begin
                share_r <= wb_dat_i[pst_pkg::CTRL_SHARE_BIT];
            end
            if (wr_iter) begin
                iter_tot_r <= (iter_tot_r & ~wmask[11:0]) | wval[11:0];
            end
            if (wr_range && wb_sel_i[0]) begin
                first_r <= wb_dat_i[3:0];
                last_r  <= wb_dat_i[pst_pkg::RANGE_LAST_LSB +: 4];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read selection; unmapped and write-only words read as zero.
    // ------------------------------------------------------------------
    wire logic [31:0] rd_word =
        (adr_w == pst_pkg::OFS_ENABLE)    ? {29'h0, enable_r} :
        (adr_w == pst_pkg::OFS_CTRL)      ? {31'h0, share_r} :
        (adr_w == pst_pkg::OFS_ITER_TOT)  ? {20'h0, iter_tot_r} :
        (adr_w == pst_pkg::OFS_SET_RANGE) ? {24'h0, last_r, first_r} :
        (adr_w == pst_pkg::OFS_SW_START)  ? {31'h0, sw_start_r} :
        (adr_w == pst_pkg::OFS_DMA_SIG)   ? {16'h0, sig_r} :
        (adr_w == pst_pkg::OFS_DONE)      ? {16'h0, done_r} :
        (adr_w == pst_pkg::OFS_CUR_SET)   ? {28'h0, idx_r} :
        (adr_w == pst_pkg::OFS_CUR_ITER)  ? {20'h0, loop_r} :
        (adr_w == pst_pkg::OFS_SEEN)      ? {13'h0, seen_r} :
        cfg_hit                           ? {19'h0, bus_cfg} :
                                            32'h0000_0000;

    // Registered answer: ack one cycle after the request, then drops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r  <= bus_req;
            rdat_r <= bus_req ? rd_word : rdat_r;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fin_last;
        state_r == pst_pkg::ST_FINISH && run_ok && at_last;
    endsequence

    sequence s_reload;
        state_r == pst_pkg::ST_LOAD ##1 state_r == pst_pkg::ST_WAIT;
    endsequence

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_timing: assert property (bus_req |=> wb_ack_o)
        else $error("request not answered in one cycle");
    a_imm_start: assert property (
        (state_r == pst_pkg::ST_LOAD && is_imm && run_ok)
            |=> compute_start_o)
        else $error("immediate set did not start");
    a_sw_hold: assert property (
        (in_wait && is_sw && !sw_start_r) |-> !compute_start_o)
        else $error("software set started without start bit");
    a_sw_consume: assert property (
        (compute_start_o && is_sw && !wr_sw) |=> !sw_start_r)
        else $error("software start bit not consumed");
    a_dma_hold: assert property (
        (in_wait && is_dma && !sig_r[cur_cfg.src]) |-> !compute_start_o)
        else $error("DMA set started without signature bit");
    a_ping_share: assert property (
        (compute_start_o && is_ping) |-> share_r)
        else $error("ping-pong start without buffer sharing");
    a_irq_cause: assert property (
        done_irq_o |-> $past(state_r) == pst_pkg::ST_FINISH
                       && $past(cur_cfg.irq_en))
        else $error("done interrupt without enabled completion");
    a_kick_dst: assert property (
        fin_kick |=> dma_kick_o[$past(cur_cfg.dst)])
        else $error("selected DMA channel not kicked");
    a_cpu_kick: assert property (
        (wr_kick && !fin_kick) |=> dma_kick_o == $past(wval[15:0]))
        else $error("software DMA kick not forwarded");
    a_done_sticky: assert property (
        (|($past(done_r) & ~done_r)) |-> $past(wr_dclr))
        else $error("done flag fell without a clear");
    a_wrap_first: assert property (
        (s_fin_last and !loop_end) |=> idx_r == $past(first_r) ##0 s_reload)
        else $error("sequencer did not wrap to first set");
    a_advance: assert property (
        (in_fin && !at_last) |=> idx_r == 4'($past(idx_r) + 4'h1))
        else $error("sequencer did not advance");
    a_forever: assert property (
        (s_fin_last and (iter_tot_r == pst_pkg::LOOP_FOREVER))
            |=> state_r != pst_pkg::ST_STOP)
        else $error("endless looping stopped");
    a_disable_idle: assert property (
        (enable_r != pst_pkg::ENABLE_ON) |=> state_r == pst_pkg::ST_IDLE
                                             && !compute_start_o)
        else $error("engine active without enable code");
    a_seen_one: assert property (seen_r[0])
        else $error("trigger-seen bit 0 not one");
    a_seen_clear: assert property (
        (wr_sclr && wval[0] && !wr_sw && !wr_sig && !pingpong_switch_i)
            |=> seen_r == pst_pkg::SEEN_RST)
        else $error("trigger-seen flags not cleared");

endmodule

/* File: tb/pst_engine_model.sv */
// Behavioural compute engine that answers each start after a delay.
`timescale 1ns/1ns
module pst_engine_model #(
    parameter int DLY = 4
) (
    // Clock and start/done handshake
    input  wire logic clk_i,
    input  wire logic start_i,
    output logic      done_o
);
    int   cnt_r  = 0;
    logic done_r = 1'b0;
    assign done_o = done_r;
    // Counts down from each start and pulses done once at the end.
    always_ff @(posedge clk_i) begin
        done_r <= (cnt_r == 1);
        cnt_r  <= start_i ? DLY : (cnt_r > 0 ? cnt_r - 1 : 0);
    end
endmodule

/* File: tb/tb_top.sv */
// Self-checking testbench for the parameter-set trigger sequencer.
`timescale 1ns/1ns
module tb_top;
    logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, irq, st, dn;
    logic        pp = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [15:0] kick;
    logic [3:0]  aset;
    int          errors = 0, cmp_count = 0;

    pst_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pingpong_switch_i(pp), .compute_done_i(dn),
        .compute_start_o(st), .active_set_o(aset), .done_irq_o(irq),
        .dma_kick_o(kick));
    pst_engine_model #(.DLY(5)) eng (.clk_i(clk_i), .start_i(st),
        .done_o(dn));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Compares a value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One classic Wishbone cycle; read data is taken at the ack edge.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 20);
        rd = rdat;
        if (n >= 20) errors++;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask

    // Waits a bounded time for a done interrupt, noting the kick lines.
    task automatic wait_irq(output logic seen, output logic [15:0] k);
        seen = 1'b0;
        k    = 16'h0;
        repeat (40) begin
            @(posedge clk_i);
            if (irq === 1'b1) begin
                seen = 1'b1;
                k    = kick;
            end
        end
    endtask

    // One-cycle ping-pong buffer switch pulse from the far side.
    task automatic ping();
        pp <= 1'b1;
        @(posedge clk_i);
        pp <= 1'b0;
    endtask

    // Programs one set, its range and a single loop, then enables.
    task automatic start_set(input logic [3:0] i, input logic [12:0] c);
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h40 + {2'h0, i, 2'h0}, {19'h0, c});
        bus(1, 8'h0c, {24'h0, i, i});
        bus(1, 8'h08, 32'h1);
        bus(1, 8'h00, 32'h7);
    endtask

    // Ends the run with the verdict.
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        #2000000;
        errors++;
        results();
    end

    // Main sequence: reset values, then one scenario per trigger mode.
    initial begin
        logic        s;
        logic [15:0] k;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, 8'h2c, 0); chk("seen_rst", rd, 32'h1);
        bus(0, 8'hfc, 0); chk("unmapped", rd, 32'h0);
        $display("test reset done");
        start_set(4'h0, 13'h0b80);
        wait_irq(s, k); chk("imm_irq", s, 1'b1);
        chk("imm_kick", k, 16'h0020);
        bus(0, 8'h18, 0); chk("done_set", rd, 32'h1);
        bus(1, 8'h1c, 32'h1);
        bus(0, 8'h18, 0); chk("done_clr", rd, 32'h0);
        $display("test immediate done");
        start_set(4'h1, 13'h0081);
        wait_irq(s, k); chk("sw_wait", s, 1'b0);
        bus(0, 8'h24, 0); chk("cur_set", rd, 32'h1);
        bus(1, 8'h10, 32'h1);
        wait_irq(s, k); chk("sw_go", s, 1'b1);
        chk("no_kick", k, 16'h0);
        bus(0, 8'h10, 0); chk("sw_self_clr", rd, 32'h0);
        bus(0, 8'h2c, 0); chk("seen_sw", rd, 32'h3);
        bus(1, 8'h30, 32'h1);
        bus(0, 8'h2c, 0); chk("seen_clr", rd, 32'h1);
        bus(1, 8'h1c, 32'hffff);
        $display("test software done");
        start_set(4'h2, 13'h00a3);
        bus(1, 8'h14, 32'h0008);
        wait_irq(s, k); chk("dma_wrong_bit", s, 1'b0);
        bus(1, 8'h14, 32'h0010);
        wait_irq(s, k); chk("dma_go", s, 1'b1);
        bus(0, 8'h18, 0); chk("dma_done", rd, 32'h4);
        bus(0, 8'h2c, 0); chk("seen_dma", rd, 32'hc1);
        $display("test dma done");
        start_set(4'h3, 13'h0082);
        ping();
        wait_irq(s, k); chk("ping_no_share", s, 1'b0);
        bus(1, 8'h04, 32'h1);
        ping();
        wait_irq(s, k); chk("ping_go", s, 1'b1);
        bus(0, 8'h2c, 0); chk("seen_ping", rd, 32'hc5);
        bus(1, 8'h20, 32'h8001); chk("cpu_kick", kick, 16'h8001);
        @(posedge clk_i); chk("kick_end", kick, 16'h0);
        $display("test ping-pong done");
        bus(1, 8'h50, 32'h0080);
        bus(1, 8'h54, 32'h0001);
        bus(1, 8'h0c, 32'h54);
        bus(1, 8'h08, 32'hfff);
        bus(1, 8'h00, 32'h6);
        wait_irq(s, k); chk("en_code", s, 1'b0);
        bus(1, 8'h00, 32'h7);
        wait_irq(s, k); chk("loop_first", s, 1'b1);
        bus(0, 8'h24, 0); chk("adv_set", rd, 32'h5);
        bus(0, 8'h28, 0); chk("iter_0", rd, 32'h0);
        bus(1, 8'h10, 32'h1);
        wait_irq(s, k); chk("wrap_irq", s, 1'b1);
        bus(0, 8'h28, 0); chk("iter_1", rd, 32'h1);
        bus(1, 8'h10, 32'h1);
        wait_irq(s, k); chk("forever", s, 1'b1);
        bus(0, 8'h28, 0); chk("iter_2", rd, 32'h2);
        $display("test loop done");
        results();
    end
endmodule
